// ==== occ_top.sv ====
// oscillator control registers with AXI4-Lite slave and switch sequencer
//
// Function
// - read-only active_source_sel shows the running clock source code
// - target_source_sel is writable, resets from initial_source_config
// - switch_request stays set while switch pending, cleared on completion
// - with switching disabled switch_request ignores writes, reads zero
// - switching disabled: target ignored, active shows initial source
// - selection_freeze set-only; with monitor enabled it blocks changes
// - pin_map_freeze changes only after unlock; one-way config makes sticky
// - PLL status reads lock; cleared on valid switch and non-PLL modes
// - clock_fail_flag set by monitor, software may only clear it
// - primary_run_in_sleep keeps primary oscillator running in sleep
// - secondary_osc_on turns 32 kHz secondary oscillator on or off
// - wake_restore_ratio makes any interrupt clear ratio_apply
// - peripheral ratio field is a power of two, 1:1 to 1:128
// - ratio_apply zero forces peripheral ratio to 1:1
// - rc_postscale_sel divides fast RC by 1..64 or 256, resets 001
// - sys_postscale_sel divides PLL branch by 1, 2, 4 or 8
// - six-bit two's complement rc_trim, zero is calibrated centre
// - all unimplemented bits read as zero
// - primary submode fixed by configuration, switches never change it
// - switching enabled only when switching_config_bit is zero
// - switch: abort if same or reserved, else clear flags, wait, settle, copy
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module occ_top (
   input  wire logic            sys_clk,
   input  wire logic            resetn,
   input  wire logic [3:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [3:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic            switching_config_bit,
   input  wire logic            monitor_config_bit,
   input  wire logic            one_way_freeze_config,
   input  wire logic [2:0]      initial_source_config,
   input  wire logic            src_ready,
   input  wire logic            src_tick,
   input  wire logic            pll_locked,
   input  wire logic            clock_fail_event,
   input  wire logic            interrupt_event,
   output logic [2:0]           active_source_sel,
   output logic                 src_start,
   output logic [2:0]           src_start_sel,
   output occ_pkg::occ_ctl_s    clk_ctl
);
   // ****************************************************
   // synchronisers and configuration capture
   // ****************************************************
   logic [1:0] rdy_s_r, tick_s_r, lock_s_r, fail_s_r, irq_s_r;
   logic       tick_d_r, fail_d_r, irq_d_r;
   logic       tick_ev, fail_ev, irq_ev;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdy_s_r  <= 2'h0;
         tick_s_r <= 2'h0;
         lock_s_r <= 2'h0;
         fail_s_r <= 2'h0;
         irq_s_r  <= 2'h0;
         tick_d_r <= 1'b0;
         fail_d_r <= 1'b0;
         irq_d_r  <= 1'b0;
      end else begin
         rdy_s_r  <= {rdy_s_r[0], src_ready};
         tick_s_r <= {tick_s_r[0], src_tick};
         lock_s_r <= {lock_s_r[0], pll_locked};
         fail_s_r <= {fail_s_r[0], clock_fail_event};
         irq_s_r  <= {irq_s_r[0], interrupt_event};
         tick_d_r <= tick_s_r[1];
         fail_d_r <= fail_s_r[1];
         irq_d_r  <= irq_s_r[1];
      end
   end
   assign tick_ev = tick_s_r[1] & ~tick_d_r;
   assign fail_ev = fail_s_r[1] & ~fail_d_r;
   assign irq_ev  = irq_s_r[1] & ~irq_d_r;

   occ_pkg::occ_cfg_s cfg_r;
   logic              cfg_ok_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_r    <= '0;
         cfg_ok_r <= 1'b0;
      end else if (!cfg_ok_r) begin
         cfg_ok_r <= 1'b1;
         cfg_r.switch_enabled  <= ~switching_config_bit;
         cfg_r.monitor_enabled <= ~switching_config_bit
                                  & ~monitor_config_bit;
         cfg_r.one_way_freeze  <= one_way_freeze_config;
         cfg_r.initial_source  <= initial_source_config;
      end
   end

   // ****************************************************
   // AXI4-Lite handshake
   // ****************************************************
   logic [3:0]  aw_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;
   logic        aw_ok_r, w_ok_r;
   logic        wr_go;
   logic [31:0] rd_val;
   logic        rd_hit;

   assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_r    <= 4'h0;
         wd_r    <= 32'h0;
         ws_r    <= 4'h0;
         aw_ok_r <= 1'b0;
         w_ok_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r    <= s_axi_awaddr;
            aw_ok_r <= 1'b1;
         end else if (wr_go) begin
            aw_ok_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_r   <= s_axi_wdata;
            ws_r   <= s_axi_wstrb;
            w_ok_r <= 1'b1;
         end else if (wr_go) begin
            w_ok_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= occ_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_r == occ_pkg::OFS_CFG_STAT) ?
                         occ_pkg::RESP_SLVERR : occ_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= occ_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? occ_pkg::RESP_OKAY
                                : occ_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************
   // unlock tracking on control register bytes
   // ****************************************************
   logic       ctl_wr, div_wr, trim_wr;
   logic [1:0] hi_st_r, lo_st_r;
   logic       hi_open, lo_open;
   logic [7:0] hi_b, lo_b;

   assign ctl_wr  = wr_go && aw_r == occ_pkg::OFS_OSC_CTRL;
   assign div_wr  = wr_go && aw_r == occ_pkg::OFS_CLK_DIV;
   assign trim_wr = wr_go && aw_r == occ_pkg::OFS_RC_TRIM;
   assign hi_b    = wd_r[15:8];
   assign lo_b    = wd_r[7:0];
   assign hi_open = hi_st_r == 2'h2;
   assign lo_open = lo_st_r == 2'h2;

   // key bytes must arrive on consecutive bus writes; any other bus write resets that byte's key state
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hi_st_r <= 2'h0;
         lo_st_r <= 2'h0;
      end else if (wr_go) begin
         if (ctl_wr && ws_r[1] && hi_st_r == 2'h0
             && hi_b == occ_pkg::KEY_HI_A) begin
            hi_st_r <= 2'h1;
         end else if (ctl_wr && ws_r[1] && hi_st_r == 2'h1
                      && hi_b == occ_pkg::KEY_HI_B) begin
            hi_st_r <= 2'h2;
         end else begin
            hi_st_r <= 2'h0;
         end
         if (ctl_wr && ws_r[0] && lo_st_r == 2'h0
             && lo_b == occ_pkg::KEY_LO_A) begin
            lo_st_r <= 2'h1;
         end else if (ctl_wr && ws_r[0] && lo_st_r == 2'h1
                      && lo_b == occ_pkg::KEY_LO_B) begin
            lo_st_r <= 2'h2;
         end else begin
            lo_st_r <= 2'h0;
         end
      end
   end

   // ****************************************************
   // control register fields
   // ****************************************************
   logic [2:0] act_src_r, tgt_src_r, pend_src_r;
   logic       sw_req_r, freeze_r, pinmap_r, pll_ok_r, fail_r;
   logic       pri_sleep_r, sec_on_r;
   logic       frozen, hi_wr_ok, lo_wr_ok, sw_done, sw_abort, sw_clear;

   assign frozen   = freeze_r & cfg_r.monitor_enabled;
   assign hi_wr_ok = ctl_wr & ws_r[1] & hi_open;
   assign lo_wr_ok = ctl_wr & ws_r[0] & lo_open;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tgt_src_r <= 3'h0;
      end else if (!cfg_ok_r) begin
         tgt_src_r <= initial_source_config;
      end else if (hi_wr_ok && !frozen) begin
         tgt_src_r <= wd_r[occ_pkg::TGT_SRC_LSB +: 3];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         act_src_r <= 3'h0;
      end else if (!cfg_ok_r) begin
         act_src_r <= initial_source_config;
      end else if (sw_done) begin
         act_src_r <= pend_src_r;
      end
   end
   assign active_source_sel = act_src_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sw_req_r <= 1'b0;
      end else if (!cfg_r.switch_enabled) begin
         sw_req_r <= 1'b0;
      end else if (sw_clear) begin
         sw_req_r <= 1'b0;
      end else if (lo_wr_ok && wd_r[occ_pkg::SW_REQ_BIT] && !frozen) begin
         sw_req_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         freeze_r    <= 1'b0;
         pinmap_r    <= 1'b0;
         pri_sleep_r <= 1'b0;
         sec_on_r    <= 1'b0;
      end else if (lo_wr_ok) begin
         freeze_r    <= freeze_r | wd_r[occ_pkg::FREEZE_BIT];
         if (!(pinmap_r && cfg_r.one_way_freeze)) begin
            pinmap_r <= wd_r[occ_pkg::PINMAP_BIT];
         end
         pri_sleep_r <= wd_r[occ_pkg::PRI_SLEEP_BIT];
         sec_on_r    <= wd_r[occ_pkg::SEC_ON_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fail_r <= 1'b0;
      end else if (fail_ev && cfg_r.monitor_enabled) begin
         fail_r <= 1'b1;
      end else if (sw_abort) begin
         fail_r <= 1'b0;
      end else if (lo_wr_ok && !wd_r[occ_pkg::FAIL_BIT]) begin
         fail_r <= 1'b0;
      end
   end

   // ****************************************************
   // switch sequencer
   // ****************************************************
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_WAIT   = 4'h2,
      ST_SETTLE = 4'h4,
      ST_DONE   = 4'h8
   } occ_st_e;
   occ_st_e st_r;
   logic    settle_go, settle_done, pll_tgt;

   assign pll_tgt  = pend_src_r == occ_pkg::SRC_FRC_PLL
                     || pend_src_r == occ_pkg::SRC_PRI_PLL;
   assign sw_abort = st_r == ST_IDLE && sw_req_r
                     && tgt_src_r != act_src_r
                     && tgt_src_r != occ_pkg::SRC_RSVD;
   assign sw_clear = (st_r == ST_IDLE && sw_req_r && !sw_abort)
                     || sw_done;
   assign settle_go = st_r == ST_WAIT && rdy_s_r[1]
                      && (!pll_tgt || lock_s_r[1]);
   assign sw_done  = st_r == ST_DONE;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r       <= ST_IDLE;
         pend_src_r <= 3'h0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (sw_abort) begin
                  pend_src_r <= tgt_src_r;
                  st_r       <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (settle_go) begin
                  st_r <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (settle_done) begin
                  st_r <= ST_DONE;
               end
            end
            ST_DONE: st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   assign src_start     = st_r == ST_WAIT;
   assign src_start_sel = pend_src_r;

   occ_settle #(
      .COUNT (occ_pkg::SETTLE_CYC)
   ) occ_settle_inst (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (settle_go),
      .tick    (tick_ev),
      .done    (settle_done)
   );

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pll_ok_r <= 1'b0;
      end else if (sw_abort) begin
         pll_ok_r <= 1'b0;
      end else if (act_src_r != occ_pkg::SRC_FRC_PLL
                   && act_src_r != occ_pkg::SRC_PRI_PLL
                   && st_r == ST_IDLE) begin
         pll_ok_r <= 1'b0;
      end else begin
         pll_ok_r <= lock_s_r[1];
      end
   end

   // ****************************************************
   // divider and trim registers
   // ****************************************************
   logic       wake_r, ratio_en_r;
   logic [2:0] ratio_r, rcps_r;
   logic [1:0] sysps_r;
   logic [5:0] trim_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ratio_en_r <= 1'b0;
      end else if (irq_ev && wake_r) begin
         ratio_en_r <= 1'b0;
      end else if (div_wr && ws_r[1]) begin
         ratio_en_r <= wd_r[occ_pkg::RATIO_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wake_r  <= 1'b0;
         ratio_r <= 3'h0;
         rcps_r  <= occ_pkg::RCPS_RST;
         sysps_r <= 2'h0;
      end else if (div_wr) begin
         if (ws_r[1]) begin
            wake_r  <= wd_r[occ_pkg::WAKE_BIT];
            ratio_r <= wd_r[occ_pkg::RATIO_LSB +: 3];
            rcps_r  <= wd_r[occ_pkg::RCPS_LSB +: 3];
         end
         if (ws_r[0]) begin
            sysps_r <= wd_r[occ_pkg::SYSPS_LSB +: 2];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trim_r <= 6'h0;
      end else if (trim_wr && ws_r[0]) begin
         trim_r <= wd_r[5:0];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clk_ctl <= '0;
      end else begin
         clk_ctl.peri_ratio_log2 <= ratio_en_r ? ratio_r : 3'h0;
         clk_ctl.rc_postscale_log2 <= rcps_r; // code 7 is /256
         clk_ctl.sys_postscale_log2 <= sysps_r;
         clk_ctl.rc_trim <= trim_r;
         clk_ctl.primary_run_in_sleep <= pri_sleep_r;
         clk_ctl.secondary_osc_on <= sec_on_r;
      end
   end

   // ****************************************************
   // read mux
   // ****************************************************
   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         occ_pkg::OFS_OSC_CTRL: begin
            rd_val[occ_pkg::ACT_SRC_LSB +: 3] = act_src_r;
            rd_val[occ_pkg::TGT_SRC_LSB +: 3] = tgt_src_r;
            rd_val[occ_pkg::FREEZE_BIT]    = freeze_r;
            rd_val[occ_pkg::PINMAP_BIT]    = pinmap_r;
            rd_val[occ_pkg::PLL_OK_BIT]    = pll_ok_r;
            rd_val[occ_pkg::FAIL_BIT]      = fail_r;
            rd_val[occ_pkg::PRI_SLEEP_BIT] = pri_sleep_r;
            rd_val[occ_pkg::SEC_ON_BIT]    = sec_on_r;
            rd_val[occ_pkg::SW_REQ_BIT]    = sw_req_r;
         end
         occ_pkg::OFS_CLK_DIV: begin
            rd_val[occ_pkg::WAKE_BIT]        = wake_r;
            rd_val[occ_pkg::RATIO_LSB +: 3]  = ratio_r;
            rd_val[occ_pkg::RATIO_EN_BIT]    = ratio_en_r;
            rd_val[occ_pkg::RCPS_LSB +: 3]   = rcps_r;
            rd_val[occ_pkg::SYSPS_LSB +: 2]  = sysps_r;
         end
         occ_pkg::OFS_RC_TRIM: rd_val[5:0] = trim_r;
         occ_pkg::OFS_CFG_STAT: begin
            rd_val[0] = cfg_r.switch_enabled;
            rd_val[1] = cfg_r.monitor_enabled;
            rd_val[2] = hi_open;
            rd_val[3] = lo_open;
            rd_val[7:4] = st_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end
endmodule

// ==== occ_pkg.sv ====
// package: register map, field layout, reset values and source codes
package occ_pkg;

   // ****************************************************
   // register offsets
   // ****************************************************
   localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
   localparam logic [3:0] OFS_CLK_DIV  = 4'h4;
   localparam logic [3:0] OFS_RC_TRIM  = 4'h8;
   localparam logic [3:0] OFS_CFG_STAT = 4'hC;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int ACT_SRC_LSB   = 12;
   localparam int TGT_SRC_LSB   = 8;
   localparam int FREEZE_BIT    = 7;
   localparam int PINMAP_BIT    = 6;
   localparam int PLL_OK_BIT    = 5;
   localparam int FAIL_BIT      = 3;
   localparam int PRI_SLEEP_BIT = 2;
   localparam int SEC_ON_BIT    = 1;
   localparam int SW_REQ_BIT    = 0;
   localparam int WAKE_BIT      = 15;
   localparam int RATIO_LSB     = 12;
   localparam int RATIO_EN_BIT  = 11;
   localparam int RCPS_LSB      = 8;
   localparam int SYSPS_LSB     = 6;

   // ****************************************************
   // reset values, unlock keys, settle count and response codes
   // ****************************************************
   localparam logic [2:0] RCPS_RST  = 3'h1;
   localparam logic [7:0] KEY_HI_A  = 8'h78;
   localparam logic [7:0] KEY_HI_B  = 8'h9A;
   localparam logic [7:0] KEY_LO_A  = 8'h46;
   localparam logic [7:0] KEY_LO_B  = 8'h57;
   localparam logic [3:0] SETTLE_CYC = 4'hA;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************
   // clock source codes
   // ****************************************************
   typedef enum logic [2:0] {
      SRC_FRC     = 3'h0,
      SRC_FRC_PLL = 3'h1,
      SRC_PRI     = 3'h2,
      SRC_PRI_PLL = 3'h3,
      SRC_SEC     = 3'h4,
      SRC_SLOW_INTERNAL_RC    = 3'h5,
      SRC_RSVD    = 3'h6,
      SRC_FRC_PS  = 3'h7
   } occ_src_e;

   typedef struct packed {
      logic       switch_enabled;
      logic       monitor_enabled;
      logic       one_way_freeze;
      logic [2:0] initial_source;
   } occ_cfg_s;

   typedef struct packed {
      logic [2:0] peri_ratio_log2;
      logic [2:0] rc_postscale_log2;
      logic [1:0] sys_postscale_log2;
      logic [5:0] rc_trim;
      logic       primary_run_in_sleep;
      logic       secondary_osc_on;
   } occ_ctl_s;

endpackage

// ==== occ_settle.sv ====
// settle counter: counts new-source clock ticks after ready
`timescale 1ns/1ps
module occ_settle #(
   parameter logic [3:0] COUNT = 4'hA
) (
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic tick,
   output logic      done
);
   logic [3:0] cnt_r;
   logic       run_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 4'h0;
         run_r <= 1'b0;
      end else if (start) begin
         cnt_r <= 4'h0;
         run_r <= 1'b1;
      end else if (run_r && tick) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == COUNT - 4'h1) begin
            run_r <= 1'b0;
         end
      end
   end

   assign done = run_r && tick && (cnt_r == COUNT - 4'h1);
endmodule

// ==== occ_chk.sv ====
// checker: bus and clock switch properties of occ_top
`timescale 1ns/1ps
module occ_chk (
   input wire logic       sys_clk,
   input wire logic       resetn,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       switching_config_bit,
   input wire logic       src_ready,
   input wire logic       src_start,
   input wire logic [2:0] src_start_sel,
   input wire logic [2:0] active_source_sel
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   chk_b_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
   chk_r_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r lost");
   chk_b_refuse: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken");
   chk_r_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
   chk_active_code: assert property (
      active_source_sel != 3'h6) else $error("reserved active");
   chk_start_target: assert property (
      $rose(src_start) |-> src_start_sel != active_source_sel
         && src_start_sel != 3'h6) else $error("bad start");
   chk_start_off: assert property (
      switching_config_bit |-> !src_start) else $error("start unexpected");
   chk_active_fixed: assert property (
      $past(resetn, 2) && $changed(active_source_sel)
         |-> !switching_config_bit) else $error("active moved");
   chk_wait_ready: assert property (
      (!src_ready)[*3] ##0 src_start |=> src_start) else $error("left wait");
endmodule
bind occ_top occ_chk occ_chk_inst (
   .sys_clk, .resetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .switching_config_bit, .src_ready, .src_start, .src_start_sel,
   .active_source_sel);

// ==== tb_occ_top.sv ====
// testbench: registers, divider, clock switch and disabled switching
`timescale 1ns/1ps
module tb_occ_top;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [3:0]        s_axi_awaddr = 4'h0;
   logic              s_axi_awvalid = 1'b0;
   logic              s_axi_awready;
   logic [31:0]       s_axi_wdata = 32'h0;
   logic [3:0]        s_axi_wstrb = 4'h0;
   logic              s_axi_wvalid = 1'b0;
   logic              s_axi_wready;
   logic [1:0]        s_axi_bresp;
   logic              s_axi_bvalid;
   logic              s_axi_bready = 1'b0;
   logic [3:0]        s_axi_araddr = 4'h0;
   logic              s_axi_arvalid = 1'b0;
   logic              s_axi_arready;
   logic [31:0]       s_axi_rdata;
   logic [1:0]        s_axi_rresp;
   logic              s_axi_rvalid;
   logic              s_axi_rready = 1'b0;
   logic              switching_config_bit = 1'b0;
   logic              monitor_config_bit = 1'b0;
   logic              one_way_freeze_config = 1'b0;
   logic [2:0]        initial_source_config = 3'h7;
   logic              src_ready = 1'b0;
   logic              src_tick = 1'b0;
   logic              pll_locked = 1'b0;
   logic              clock_fail_event = 1'b0;
   logic              interrupt_event = 1'b0;
   logic [2:0]        active_source_sel;
   logic              src_start;
   logic [2:0]        src_start_sel;
   occ_pkg::occ_ctl_s clk_ctl;
   int                fails = 0;
   int                samples_checked = 0;
   logic [31:0]       v;
   logic [1:0]        r;
   occ_top occ_top_inst (.*);
   initial forever #2 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rst(input logic sw, input logic [2:0] src);
      @(posedge sys_clk);
      resetn <= 1'b0;
      switching_config_bit <= sw;
      initial_source_config <= src;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic ctl(input logic hi, input logic [7:0] d);
      logic [3:0] s;
      logic [7:0] ka;
      logic [7:0] kb;
      s = hi ? 4'h2 : 4'h1;
      ka = hi ? occ_pkg::KEY_HI_A : occ_pkg::KEY_LO_A;
      kb = hi ? occ_pkg::KEY_HI_B : occ_pkg::KEY_LO_B;
      wr(4'h0, {16'h0, ka, ka}, s);
      wr(4'h0, {16'h0, kb, kb}, s);
      wr(4'h0, {16'h0, d, d}, s);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         src_tick <= 1'b1;
         repeat (2) @(posedge sys_clk);
         src_tick <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   task automatic irq;
      @(posedge sys_clk);
      interrupt_event <= 1'b1;
      repeat (4) @(posedge sys_clk);
      interrupt_event <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic t_reset;
      rd(4'h0);
      chk("osc", 32'h7700, v);
      chk("rresp", occ_pkg::RESP_OKAY, r);
      rd(4'h4);
      chk("div", 32'h0100, v);
      wr(4'hC, 32'hFFFF, 4'hF);
      chk("resp", occ_pkg::RESP_SLVERR, r);
   endtask
   task automatic t_div;
      wr(4'h8, 32'hFFFFFFFF, 4'hF);
      rd(4'h8);
      chk("trim", 32'h3F, v);
      wr(4'h4, 32'hFFFFFFFF, 4'hF);
      rd(4'h4);
      chk("div", 32'hFFC0, v);
      chk("ctl", 32'hFFFC, 32'(clk_ctl));
      irq;
      rd(4'h4);
      chk("div", 32'hF7C0, v);
      chk("ctl", 32'h1FFC, 32'(clk_ctl));
      wr(4'h4, 32'h7FC0, 4'h3);
      irq;
      rd(4'h4);
      chk("div", 32'h7FC0, v);
   endtask
   task automatic t_switch;
      wr(4'h0, 32'h0500, 4'h2);
      rd(4'h0);
      chk("osc", 32'h7700, v);
      ctl(1'b1, 8'h00);
      ctl(1'b0, 8'h07);
      rd(4'h0);
      chk("osc", 32'h7007, v);
      chk("start", 1, src_start);
      chk("sel", 0, src_start_sel);
      chk("ctl", 32'hFFFF, 32'(clk_ctl));
      src_ready <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ticks(9);
      chk("act", 7, active_source_sel);
      ticks(1);
      repeat (8) @(posedge sys_clk);
      chk("act", 0, active_source_sel);
      rd(4'h0);
      chk("osc", 32'h0006, v);
      ctl(1'b0, 8'h07);
      repeat (4) @(posedge sys_clk);
      chk("start", 0, src_start);
      ctl(1'b1, 8'h06);
      ctl(1'b0, 8'h07);
      rd(4'h0);
      chk("osc", 32'h0606, v);
   endtask
   task automatic t_fail;
      pll_locked <= 1'b1;
      clock_fail_event <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd(4'h0);
      chk("osc", 32'h060E, v);
      ctl(1'b0, 8'hC6);
      rd(4'h0);
      chk("osc", 32'h06C6, v);
      ctl(1'b1, 8'h00);
      rd(4'h0);
      chk("osc", 32'h06C6, v);
   endtask
   task automatic t_disabled;
      rst(1'b1, 3'h4);
      rd(4'h0);
      chk("osc", 32'h4400, v);
      ctl(1'b0, 8'h01);
      rd(4'h0);
      chk("req", 0, v[0]);
      chk("act", 4, active_source_sel);
   endtask
   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict;
   end
   initial begin
      rst(1'b0, 3'h7);
      t_reset;
      t_div;
      t_switch;
      t_fail;
      t_disabled;
      give_verdict;
   end
endmodule
